// ===== hdl/fo_pkg.sv
// Shared constants, types and state layouts of the reference failover block
package fo_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int REF_PERIOD_NS = 800;
   localparam int STUCK_CYCLES = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;

   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   localparam int AW = 4;
   localparam int DW = 32;
   localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
   localparam logic [AW-1:0] ADDR_STATUS = 4'h4;
   localparam logic [AW-1:0] ADDR_IRQ_STAT = 4'h8;
   localparam logic [AW-1:0] ADDR_IRQ_MASK = 4'hc;
   localparam int CTRL_AUTO = 0;
   localparam int CTRL_PREF = 1;
   localparam int STAT_FAIL0 = 0;
   localparam int STAT_FAIL1 = 1;
   localparam int STAT_ACTIVE = 2;
   localparam int STAT_TARGET = 3;
   localparam int STAT_RUN = 4;
   localparam int STAT_STATE = 5;
   localparam int IRQ_W = 4;
   localparam int IRQ_FAIL0 = 0;
   localparam int IRQ_FAIL1 = 1;
   localparam int IRQ_SWITCH = 2;
   localparam int IRQ_STALL = 3;

   typedef struct packed {
      logic we;
      logic re;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } fo_bus_req_s;

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FO_RUN = 2'h0,
      FO_ARM = 2'h1,
      FO_STALL = 2'h3
   } fo_state_e;

   typedef struct packed {
      logic auto_en;
      logic pref_sel;
      logic [1:0] fail_n;
      logic target;
      logic active;
      fo_state_e state;
      logic pll_run;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic irq;
      logic [DW-1:0] rdata;
   } fo_main_s;

   localparam fo_main_s MAIN_RST = '{auto_en: 1'b0, pref_sel: 1'b0, fail_n: 2'h3,
      target: 1'b0, active: 1'b0, state: FO_RUN, pll_run: 1'b1, irq_stat: 4'h0,
      irq_mask: 4'h0, irq: 1'b0, rdata: 32'h0};

   typedef struct packed {
      logic prev;
      logic valid;
      logic [CNT_W-1:0] cnt;
      logic fall;
      logic stuck;
   } fo_mon_s;

   localparam fo_mon_s MON_RST = '{prev: 1'b0, valid: 1'b0, cnt: 8'h0, fall: 1'b0,
      stuck: 1'b0};

   typedef struct packed {
      logic prev;
      logic pulse;
   } fo_clr_s;

   localparam fo_clr_s CLR_RST = '{prev: 1'b1, pulse: 1'b0};

endpackage : fo_pkg

// ===== hdl/fo_edge_mon.sv
// Stuck-clock monitor for one reference input
`timescale 1ns/1ps
module fo_edge_mon #(
   parameter int STUCK = fo_pkg::STUCK_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_in,
   input wire logic clr,
   output logic fall,
   output logic stuck
);
   import fo_pkg::*;

   localparam logic [CNT_W-1:0] LIM = CNT_W'(STUCK);

   fo_mon_s q;
   fo_mon_s next_q;

   // ------------------------------------------------------------
   // Edge window
   // ------------------------------------------------------------
   always_comb begin
      next_q = q;
      next_q.prev = clk_in;
      next_q.fall = q.prev & ~clk_in;
      if (clk_in != q.prev) begin
         next_q.cnt = '0;
         next_q.valid = 1'b1;
      end else if (clr) begin
         next_q.cnt = '0;
      end else if (q.cnt != LIM) begin
         next_q.cnt = q.cnt + 8'h1;
      end
      next_q.stuck = next_q.valid & (next_q.cnt == LIM);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= MON_RST;
      end else begin
         q <= next_q;
      end
   end

   assign fall = q.fall;
   assign stuck = q.stuck;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_EDGE_CLEARS_STUCK: assert property (clk_in != q.prev |=> !q.stuck)
      else $error("stuck raised despite an edge");
   AST_STUCK_NEEDS_VALID: assert property (q.stuck |-> q.valid && $stable(q.prev))
      else $error("stuck without a prior valid clock");

endmodule : fo_edge_mon

// ===== hdl/fo_clr_pulse.sv
// One-shot pulse on the falling edge of the flag-clear pin
`timescale 1ns/1ps
module fo_clr_pulse (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clear_n,
   output logic pulse
);
   import fo_pkg::*;

   fo_clr_s q;
   fo_clr_s next_q;

   always_comb begin
      next_q.prev = clear_n;
      next_q.pulse = q.prev & ~clear_n;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= CLR_RST;
      end else begin
         q <= next_q;
      end
   end

   assign pulse = q.pulse;

   AST_SINGLE_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
      q.pulse |=> !q.pulse)
      else $error("flag-clear pulse longer than one cycle");

endmodule : fo_clr_pulse

// ===== hdl/fo_failover.sv
// Failure monitor and reference switch for two redundant clock inputs
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module fo_failover (
   input wire logic clock,
   input wire logic rstn,
   input wire logic ref_input_zero,
   input wire logic ref_input_one,
   input wire logic alarm_clear_n,
   input fo_pkg::fo_bus_req_s bus_req,
   output logic [fo_pkg::DW-1:0] rd_data,
   output logic [1:0] input_fail_flag_n,
   output logic active_input_indicator,
   output logic pll_run,
   output logic irq
);
   import fo_pkg::*;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // Input monitors
   // ------------------------------------------------------------
   logic [1:0] ref_in;
   logic [1:0] fall;
   logic [1:0] stuck;
   logic clr;

   assign ref_in = {ref_input_one, ref_input_zero};

   fo_clr_pulse u_clr (
      .clock(clock),
      .rst_n(rst_n),
      .clear_n(alarm_clear_n),
      .pulse(clr)
   );

   generate
      for (genvar i = 0; i < 2; i++) begin : g_mon
         // Both inputs always watched, whatever the mode
         fo_edge_mon #(
            .STUCK(STUCK_CYCLES)
         ) u_mon (
            .clock(clock),
            .rst_n(rst_n),
            .clk_in(ref_in[i]),
            .clr(clr),
            .fall(fall[i]),
            .stuck(stuck[i])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Main state
   // ------------------------------------------------------------
   fo_main_s q;
   fo_main_s next_q;
   logic [1:0] new_fail;
   logic [IRQ_W-1:0] irq_ev;
   logic [IRQ_W-1:0] w1c;
   logic pref;
   logic held;

   always_comb begin
      next_q = q;
      irq_ev = '0;
      w1c = '0;
      pref = q.pref_sel;
      held = ~&q.fail_n;
      new_fail = stuck & q.fail_n;

      // Register writes
      if (bus_req.we) begin
         unique case (bus_req.addr)
            ADDR_CTRL: begin
               next_q.auto_en = bus_req.wdata[CTRL_AUTO];
               next_q.pref_sel = bus_req.wdata[CTRL_PREF];
            end
            ADDR_IRQ_STAT: w1c = bus_req.wdata[IRQ_W-1:0];
            ADDR_IRQ_MASK: next_q.irq_mask = bus_req.wdata[IRQ_W-1:0];
            default: begin
            end
         endcase
      end

      // Register reads, data in the following cycle
      next_q.rdata = '0;
      if (bus_req.re) begin
         unique case (bus_req.addr)
            ADDR_CTRL: begin
               next_q.rdata[CTRL_AUTO] = q.auto_en;
               next_q.rdata[CTRL_PREF] = q.pref_sel;
            end
            ADDR_STATUS: begin
               next_q.rdata[STAT_FAIL0] = q.fail_n[0];
               next_q.rdata[STAT_FAIL1] = q.fail_n[1];
               next_q.rdata[STAT_ACTIVE] = q.active;
               next_q.rdata[STAT_TARGET] = q.target;
               next_q.rdata[STAT_RUN] = q.pll_run;
               next_q.rdata[STAT_STATE +: 2] = q.state;
            end
            ADDR_IRQ_STAT: next_q.rdata[IRQ_W-1:0] = q.irq_stat;
            ADDR_IRQ_MASK: next_q.rdata[IRQ_W-1:0] = q.irq_mask;
            default: next_q.rdata = '0;
         endcase
      end

      // Failure flags, a new failure beats the clear
      for (int i = 0; i < 2; i++) begin
         if (clr) begin
            next_q.fail_n[i] = 1'b1;
         end
         if (stuck[i]) begin
            next_q.fail_n[i] = 1'b0;
         end
      end
      irq_ev[IRQ_FAIL0] = new_fail[0];
      irq_ev[IRQ_FAIL1] = new_fail[1];

      // Reference choice
      if (!q.auto_en || !held || clr) begin
         next_q.target = pref;
      end
      if (q.auto_en && new_fail[q.target] && q.fail_n[~q.target] && !stuck[~q.target]) begin
         next_q.target = ~q.target;
      end

      // Switch sequencing
      unique case (q.state)
         FO_RUN: begin
            if (next_q.fail_n == 2'h0) begin
               next_q.state = FO_STALL;
               irq_ev[IRQ_STALL] = 1'b1;
            end else if (next_q.target != q.active) begin
               next_q.state = FO_ARM;
            end
         end
         FO_ARM: begin
            if (next_q.fail_n == 2'h0) begin
               next_q.state = FO_STALL;
               irq_ev[IRQ_STALL] = 1'b1;
            end else if (q.target == q.active) begin
               next_q.state = FO_RUN;
            end else if (fall[q.target]) begin
               next_q.active = q.target;
               next_q.state = FO_RUN;
               irq_ev[IRQ_SWITCH] = 1'b1;
            end
         end
         FO_STALL: begin
            if (next_q.fail_n != 2'h0) begin
               next_q.state = FO_RUN;
            end
         end
         default: next_q.state = FO_RUN;
      endcase
      next_q.pll_run = (next_q.state != FO_STALL);

      // Sticky events, set wins over clear
      next_q.irq_stat = (q.irq_stat & ~w1c) | irq_ev;
      next_q.irq = |(next_q.irq_stat & next_q.irq_mask);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= MAIN_RST;
      end else begin
         q <= next_q;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rd_data = q.rdata;
   assign input_fail_flag_n = q.fail_n;
   assign active_input_indicator = q.active;
   assign pll_run = q.pll_run;
   assign irq = q.irq;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_FLAG_SET: assert property (stuck[0] |=> !input_fail_flag_n[0])
      else $error("input zero failure not flagged");
   AST_FLAG_LATCH: assert property (!q.fail_n[1] && !clr |=> !q.fail_n[1])
      else $error("input one flag released without clear");
   AST_CLR_RELEASE: assert property (clr && !stuck[0] |=> q.fail_n[0])
      else $error("clear pulse did not release flag");
   AST_MANUAL_TARGET: assert property (!q.auto_en |=> q.target == $past(q.pref_sel))
      else $error("manual mode reference not the select");
   AST_FREE_FOLLOW: assert property (q.auto_en && q.fail_n == 2'h3 && stuck == 2'h0
      |=> q.target == $past(q.pref_sel))
      else $error("indicator target not following select");
   AST_FAILOVER: assert property (q.auto_en && new_fail[q.target] && q.fail_n[~q.target]
      && !stuck[~q.target] |=> q.target != $past(q.target))
      else $error("no failover to valid alternate");
   AST_SWITCH_ON_FALL: assert property (q.active != $past(q.active)
      |-> (q.active ? $past(fall[1]) : $past(fall[0])))
      else $error("switch not on falling edge of new input");
   AST_IND_LANDS: assert property (q.state == FO_ARM && fall[q.target]
      && next_q.fail_n != 2'h0 |=> active_input_indicator == $past(q.target))
      else $error("indicator not showing reference in use");
   AST_STALL: assert property (q.fail_n == 2'h0 && !clr |=> !pll_run)
      else $error("PLL still running with both inputs lost");

   COV_FAILOVER: cover property (q.auto_en && new_fail[q.pref_sel] ##[1:40]
      q.active != q.pref_sel);
   COV_STALL: cover property (q.state == FO_STALL);
   COV_MANUAL_SWITCH: cover property (!q.auto_en && $changed(q.active));

endmodule : fo_failover

// ===== test/fo_ref_src.sv
// Model of the two redundant reference clock sources
`timescale 1ns/1ps
module fo_ref_src (
   input wire logic clock,
   input wire logic [1:0] run,
   input wire logic [7:0] half,
   output logic [1:0] refs
);
   int cnt [2];
   initial begin
      refs = 2'h0;
      cnt[0] = 0;
      cnt[1] = 0;
   end
   // --------------------------------------------------------------
   // Sources
   // --------------------------------------------------------------
   // A stopped source holds its last level, the stuck fault
   always @(posedge clock) begin
      for (int i = 0; i < 2; i++) begin
         if (run[i]) begin
            if (cnt[i] + 1 >= int'(half[4*i+:4])) begin
               cnt[i] <= 0;
               refs[i] <= ~refs[i];
            end else begin
               cnt[i] <= cnt[i] + 1;
            end
         end
      end
   end
endmodule : fo_ref_src

// ===== test/redundant_ref_clock_failover_test.sv
// Self-checking bench of the reference failover block
`timescale 1ns/1ps
module redundant_ref_clock_failover_test;
   import fo_pkg::*;
   localparam int SETTLE = 3 * STUCK_CYCLES + 8;
   localparam int LIMIT = 5000;
   logic clock = 1'b0;
   logic rstn;
   logic alarm_clear_n;
   fo_bus_req_s bus_req;
   logic [DW-1:0] rd_data;
   logic [1:0] input_fail_flag_n;
   logic active_input_indicator;
   logic pll_run;
   logic irq;
   logic [1:0] run;
   logic [7:0] half;
   logic [1:0] refs;
   logic [1:0] m_fail;
   logic m_ind;
   logic m_run;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   int seed;
   always #50 clock = ~clock;
   fo_ref_src fo_ref_src_inst (.clock(clock), .run(run), .half(half), .refs(refs));
   fo_failover fo_failover_inst (.clock(clock), .rstn(rstn), .ref_input_zero(refs[0]),
      .ref_input_one(refs[1]), .alarm_clear_n(alarm_clear_n), .bus_req(bus_req),
      .rd_data(rd_data), .input_fail_flag_n(input_fail_flag_n),
      .active_input_indicator(active_input_indicator), .pll_run(pll_run), .irq(irq));
   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task test_done;
      $display("Checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %0s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task chk_out;
      chk("fail_n", {30'h0, ~m_fail}, {30'h0, input_fail_flag_n});
      chk("pll_run", {31'h0, m_run}, {31'h0, pll_run});
   endtask : chk_out
   task chk_ind;
      chk("indicator", {31'h0, m_ind}, {31'h0, active_input_indicator});
   endtask : chk_ind
   task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clock);
      bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      bus_req.we <= 1'b0;
   endtask : wr
   task rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge clock);
      bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clock);
      bus_req.re <= 1'b0;
      @(negedge clock);
      chk("rd_data", e, rd_data);
   endtask : rd
   task settle;
      repeat (SETTLE) @(posedge clock);
      @(negedge clock);
   endtask : settle
   task mode(input logic a, input logic p);
      wr(ADDR_CTRL, {30'h0, p, a});
   endtask : mode
   task recover;
      run <= 2'h3;
      settle;
      @(posedge clock);
      alarm_clear_n <= 1'b0;
      repeat (4) @(posedge clock);
      alarm_clear_n <= 1'b1;
      settle;
      m_fail = 2'h0;
      m_run = 1'b1;
   endtask : recover
   task tend(input string n);
      $display("Test %0s done", n);
   endtask : tend
   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         test_done;
      end
   end
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      alarm_clear_n = 1'b1;
      bus_req = '0;
      run = 2'h3;
      half = 8'h44;
      seed = 3;
      m_fail = 2'h0;
      m_ind = 1'b0;
      m_run = 1'b1;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk_out;
      chk_ind;
      rd(ADDR_STATUS, 32'h13);
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_IRQ_MASK, 32'h0);
      rd(ADDR_IRQ_STAT, 32'h0);
      rd(4'h2, 32'h0);
      tend("reset");
      mode(1'b0, 1'b1);
      m_ind = 1'b1;
      settle;
      chk_ind;
      mode(1'b0, 1'b0);
      m_ind = 1'b0;
      settle;
      chk_ind;
      run <= 2'h1;
      settle;
      m_fail = 2'h2;
      chk_out;
      run <= 2'h3;
      settle;
      chk_out;
      mode(1'b0, 1'b1);
      m_ind = 1'b1;
      settle;
      chk_ind;
      mode(1'b0, 1'b0);
      m_ind = 1'b0;
      recover;
      chk_out;
      chk_ind;
      tend("manual");
      mode(1'b1, 1'b0);
      rd(ADDR_CTRL, 32'h1);
      for (int k = 0; k < 4; k++) begin
         half <= {4'(1 + ($random(seed) & 3)), 4'(1 + ($random(seed) & 3))};
         settle;
         chk_out;
      end
      half <= 8'h44;
      tend("frequency");
      wr(ADDR_IRQ_STAT, 32'hf);
      wr(ADDR_IRQ_MASK, 32'h1);
      run <= 2'h2;
      settle;
      m_fail = 2'h1;
      m_ind = 1'b1;
      chk_out;
      chk_ind;
      chk("irq", 32'h1, {31'h0, irq});
      rd(ADDR_IRQ_STAT, 32'h5);
      wr(ADDR_IRQ_STAT, 32'h1);
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk("irq", 32'h0, {31'h0, irq});
      rd(ADDR_IRQ_STAT, 32'h4);
      m_ind = 1'b0;
      recover;
      chk_out;
      chk_ind;
      tend("failover");
      mode(1'b1, 1'b1);
      m_ind = 1'b1;
      settle;
      chk_ind;
      run <= 2'h1;
      settle;
      m_fail = 2'h2;
      m_ind = 1'b0;
      chk_out;
      chk_ind;
      m_ind = 1'b1;
      recover;
      chk_ind;
      tend("preferred one");
      run <= 2'h2;
      settle;
      m_fail = 2'h1;
      chk_out;
      chk_ind;
      run <= 2'h0;
      settle;
      m_fail = 2'h3;
      m_run = 1'b0;
      chk_out;
      chk_ind;
      rd(ADDR_STATUS, 32'h6c);
      recover;
      chk_out;
      tend("both lost");
      test_done;
   end
endmodule : redundant_ref_clock_failover_test
